// File: bench/bsr_seq.sv
// sequencer model: presents instruction fields and operands each cycle
// assumes the bench calls issue() and that the block drives the port only while its enable is low
`timescale 1ns/10ps
module bsr_seq
    import bsr_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic port_oen, // low while the block drives the port
    input wire logic [3:0] port_o, // value the block puts on the port
    output bsr_pkg::bsr_instr_t instr, // instruction fields
    output logic sv_oe, // port enable, low lets the block drive
    output logic [3:0] port_i, // resolved port level
    output logic [15:0] shift_in, // shifter operand
    output logic [15:0] alu_in // alu register-file operand
);
    logic [3:0] drive_v; // value this side puts on the port
    logic [3:0] float_v; // level of a port that nobody drives

    // idle fields from time zero
    initial begin
        instr = '{4'h0, hold_show_left, hold_show_right};
        sv_oe = 1'b1;
        drive_v = 4'h0;
        float_v = 4'hA;
        shift_in = 16'h0000;
        alu_in = 16'h0000;
    end

    // a floating port changes every cycle so a stale value never passes for a driven one
    always @(posedge clk) begin
        float_v <= float_v + 4'h5;
    end

    // wire resolution from both enables
    assign port_i = sv_oe ? drive_v : (port_oen ? float_v : port_o);

    // present one cycle of fields right after a rising edge
    task automatic issue(input bsr_instr_t i, input logic [15:0] s, input logic [15:0] a,
                         input logic e, input logic [3:0] v);
        @(posedge clk);
        instr <= i;
        shift_in <= s;
        alu_in <= a;
        sv_oe <= e;
        drive_v <= v;
    endtask
endmodule

// File: bench/bsr_top_tb.sv
// self-checking bench for the shifter and register-file block
// assumes the sequencer model in bsr_seq and zero-wait apb answers
`timescale 1ns/10ps
module bsr_top_tb;
    import bsr_pkg::*;
    // expected datapath outputs of one cycle
    typedef struct packed {
        logic [15:0] sh;
        logic [15:0] alu;
        logic oen;
        logic [3:0] pv;
    } bsr_dnote_t;
    // expected bus answer
    typedef struct packed {
        logic wr;
        logic [31:0] data;
        logic err;
    } bsr_anote_t;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, probe, sv_oe, port_oen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, w;
    bsr_instr_t instr;
    logic [3:0] port_i, port_o, op, m_a, m_b, m_sv; // m_ are reference registers
    logic [15:0] shift_in, alu_in, sh_out, alu_out;
    logic [15:0] m_rf [4]; // reference: shifter left, right, alu left, right
    logic [15:0] corner [6] = '{16'h0000, 16'hFFFF, 16'h4000, 16'hBFFF, 16'h0001, 16'hFFFE};
    int mismatches, cmp_count;
    integer seed;
    bsr_dnote_t dq[$];
    bsr_anote_t aq[$];
    bsr_dnote_t dn;
    bsr_anote_t an;

    bsr_top bsr_top_i (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .INSTR(instr), .SHIFT_VALUE_OUTPUT_ENABLE(sv_oe),
        .SHIFT_VALUE_PORT_I(port_i), .SHIFT_VALUE_PORT_O(port_o),
        .SHIFT_VALUE_PORT_OEN(port_oen), .SHIFT_IN(shift_in), .ALU_IN(alu_in),
        .SHIFT_RF_OUT(sh_out), .ALU_RF_OUT(alu_out));
    bsr_seq bsr_seq_i (.clk(clk), .port_oen(port_oen), .port_o(port_o), .instr(instr),
        .sv_oe(sv_oe), .port_i(port_i), .shift_in(shift_in), .alu_in(alu_in));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // places to shift left until the top two bits differ, at most 15
    function automatic logic [3:0] norm_count(input logic [15:0] x);
        logic [3:0] n;
        n = 4'h0;
        while (n != 4'hF && x[15] == x[14]) begin
            x = x << 1;
            n = n + 4'h1;
        end
        return n;
    endfunction

    // sign-filling right shift, one place at a time
    function automatic logic [15:0] sra(input logic [15:0] x, input logic [3:0] n);
        repeat (n) x = {x[15], x[15:1]};
        return x;
    endfunction

    // register-file output for a code; base 0 is the shifter file, 2 the alu file
    function automatic logic [15:0] rf_show(input int base, input logic [2:0] c,
                                            input logic [15:0] d);
        if (c == 3'h7) return d;
        if (c == 3'h0 || c == 3'h3 || c == 3'h5) return m_rf[base + 1];
        return m_rf[base];
    endfunction

    // register-file loads at the closing edge
    task automatic rf_load(input int base, input logic [2:0] c, input logic [15:0] d);
        if (c == 3'h0 || c == 3'h2 || c == 3'h4) m_rf[base] = d;
        if (c == 3'h1 || c == 3'h3 || c == 3'h4) m_rf[base + 1] = d;
    endtask

    // one comparison, counted
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one instruction cycle; notes the expected outputs and moves the reference on
    task automatic step(input logic [3:0] o, input logic [2:0] srf, input logic [2:0] arf,
                        input logic [15:0] s, input logic [15:0] a, input logic e,
                        input logic [3:0] v, input logic pr);
        bsr_instr_t ins;
        bsr_dnote_t n;
        logic [15:0] res;
        logic [3:0] pc;
        ins.shift_op = o;
        ins.shift_rf = bsr_rcode_t'(srf);
        ins.alu_rf = bsr_rcode_t'(arf);
        bsr_seq_i.issue(ins, s, a, e, v);
        probe <= pr;
        pc = norm_count(s);
        case (o)
            4'hA: res = sra(s, m_sv);
            4'hB: res = sra(s, m_a);
            4'hC: res = sra(s, m_b);
            4'hD, 4'hE, 4'hF: res = s << pc;
            default: res = s;
        endcase
        n.sh = rf_show(0, srf, res);
        n.alu = rf_show(2, arf, a);
        n.oen = e | (o < 4'hD);
        n.pv = n.oen ? 4'h0 : pc;
        if (pr) dq.push_back(n);
        rf_load(0, srf, res);
        rf_load(2, arf, a);
        if (e) m_sv = v;
        if (o == 4'h8) m_a = v;
        if (o == 4'h9) m_b = v;
        if (o == 4'hE) m_a = pc;
        if (o == 4'hF) m_b = pc;
    endtask

    // one apb transfer behind an idle instruction cycle
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        bsr_anote_t n;
        logic [15:0] s;
        int k;
        s = 16'($random(seed));
        step(4'h0, 3'h6, 3'h5, s, s, 1'b1, m_sv, 1'b0);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        n.wr = wr;
        n.err = !(ad == 8'h00 || ad == 8'h04);
        n.data = (ad == 8'h00) ? {20'h0, m_b, 4'h0, m_a} : 32'h0;
        if (ad == 8'h04) n.data = {23'h0, 1'b0, norm_count(s), m_sv};
        aq.push_back(n);
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            mismatches++;
            tally_and_finish();
        end
        if (wr && ad == 8'h00) begin
            m_a = d[3:0];
            m_b = d[11:8];
        end
    endtask

    // reset behind an idle cycle, then clear the reference
    task automatic do_reset();
        step(4'h0, 3'h6, 3'h5, 16'h0, 16'h0, 1'b1, 4'h0, 1'b0);
        nrst <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        m_a = 4'h0;
        m_b = 4'h0;
        m_sv = 4'h0;
        m_rf = '{16'h0, 16'h0, 16'h0, 16'h0};
    endtask

    // print the counts and the verdict, then stop
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // take the oldest note whenever a result is on the outputs
    always @(negedge clk) begin
        if (probe === 1'b1 && dq.size() > 0) begin
            dn = dq.pop_front();
            check("shifter out", 32'(dn.sh), 32'(sh_out));
            check("alu out", 32'(dn.alu), 32'(alu_out));
            check("port enable", 32'(dn.oen), 32'(port_oen));
            check("port value", 32'(dn.pv), 32'(port_o));
        end
        if (psel && penable && pready === 1'b1 && aq.size() > 0) begin
            an = aq.pop_front();
            check("bus error", 32'(an.err), 32'(pslverr));
            if (!an.wr) begin
                check("read data", an.data, prdata);
            end
        end
    end

    // watchdog
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        seed = 32'h8730FDB3;
        {nrst, psel, penable, pwrite, probe} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0;
        cmp_count = 0;
        do_reset();
        apb(1'b0, 8'h00, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        // port loads, then sign fill at amounts 15, 1 and 7
        step(4'h8, 3'h7, 3'h7, 16'h1234, 16'h0, 1'b1, 4'hF, 1'b1);
        step(4'h9, 3'h7, 3'h7, 16'h8421, 16'h0, 1'b1, 4'h1, 1'b1);
        step(4'hB, 3'h7, 3'h7, 16'h8000, 16'h0, 1'b1, 4'h0, 1'b1);
        step(4'hC, 3'h7, 3'h7, 16'h8001, 16'h0, 1'b1, 4'h7, 1'b1);
        step(4'hA, 3'h7, 3'h7, 16'hF0F0, 16'h0, 1'b1, 4'h3, 1'b1);
        // normalise corners, port enable alternating
        for (int i = 0; i < 6; i++) begin
            step(4'(13 + i % 3), 3'h7, 3'h7, corner[i], 16'h0, i[0], 4'h5, 1'b1);
        end
        apb(1'b0, 8'h00, 32'h0);
        // every register-file code in both files first, then random traffic
        for (int c = 0; c < 200; c++) begin
            r = $random(seed);
            w = $random(seed);
            op = {1'b1, r[2:0]};
            step(op, (c < 8) ? c[2:0] : r[5:3], (c < 8) ? ~c[2:0] : r[8:6], w[15:0], w[31:16],
                 r[9] | (op[3:1] == 3'b100), r[13:10], 1'b1);
        end
        // register writes and unmapped places
        w = $random(seed);
        apb(1'b1, 8'h00, w);
        apb(1'b0, 8'h00, 32'h0);
        step(4'hB, 3'h7, 3'h7, 16'h9C31, 16'h0, 1'b1, 4'h2, 1'b1);
        step(4'hC, 3'h7, 3'h7, 16'h7C31, 16'h0, 1'b1, 4'h2, 1'b1);
        apb(1'b1, 8'h08, ~w);
        apb(1'b0, 8'h0C, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        // reset in mid-run clears every register
        do_reset();
        apb(1'b0, 8'h00, 32'h0);
        step(4'h0, 3'h5, 3'h6, 16'h1111, 16'h2222, 1'b1, 4'h0, 1'b1);
        step(4'h0, 3'h6, 3'h5, 16'h3333, 16'h4444, 1'b1, 4'h0, 1'b1);
        tally_and_finish();
    end
endmodule

// File: core/bsr_pkg.sv
// shared constants, types and helper functions for the shifter and register-file block
// assumes one 200 MHz clock and an apb master for the register side
package bsr_pkg;

    // datapath widths
    localparam int BSR_DW = 16; // data width of shifter and register files
    localparam int BSR_AW = 4; // width of a shift amount

    // apb register byte offsets
    localparam logic [7:0] BSR_OFS_AMOUNT = 8'h00; // amount registers a and b, read/write
    localparam logic [7:0] BSR_OFS_STATUS = 8'h04; // live shifter state, read only

    // amount register field positions
    localparam int BSR_AMT_A_LSB = 0; // amount a in bits 3:0
    localparam int BSR_AMT_B_LSB = 8; // amount b in bits 11:8

    // status register field positions
    localparam int BSR_ST_SVREG_LSB = 0; // shift-value register in bits 3:0
    localparam int BSR_ST_PRIO_LSB = 4; // priority-encoder count in bits 7:4
    localparam int BSR_ST_DRIVE_BIT = 8; // port currently driven by the block

    // reset values
    localparam logic [3:0] BSR_AMT_RST = 4'h0; // amount and shift-value registers
    localparam logic [15:0] BSR_RF_RST = 16'h0000; // register-file entries
    localparam logic [31:0] BSR_RDATA_RST = 32'h00000000; // apb read data

    // shifter operation codes, upper half of the shifter instruction space
    typedef enum logic [3:0] {
        load_amount_a_from_port = 4'h8,
        load_amount_b_from_port = 4'h9,
        arith_right_by_port_value = 4'hA,
        arith_right_by_amount_a = 4'hB,
        arith_right_by_amount_b = 4'hC,
        normalise_only = 4'hD,
        normalise_store_a = 4'hE,
        normalise_store_b = 4'hF
    } bsr_sop_t;

    // register-file instruction codes
    typedef enum logic [2:0] {
        load_left_show_right = 3'h0,
        load_right_show_left = 3'h1,
        load_left_show_left = 3'h2,
        load_right_show_right = 3'h3,
        load_both_show_left = 3'h4,
        hold_show_right = 3'h5,
        hold_show_left = 3'h6,
        hold_pass_through = 3'h7
    } bsr_rcode_t;

    // instruction fields presented by the sequencer each cycle
    typedef struct packed {
        logic [3:0] shift_op; // shifter operation
        bsr_rcode_t shift_rf; // shifter register-file code
        bsr_rcode_t alu_rf; // alu register-file code
    } bsr_instr_t;

    // state of one register file
    typedef struct packed {
        logic [15:0] left; // left entry
        logic [15:0] right; // right entry
    } bsr_rf_t;

    // state of the top level
    typedef struct packed {
        logic [3:0] amt_a; // shift amount register a
        logic [3:0] amt_b; // shift amount register b
        logic [3:0] sv_reg; // shift-value register
        logic [31:0] prdata; // apb read data captured in setup
        logic pslverr; // apb error captured in setup
    } bsr_state_t;

    // leading copies of the sign bit below the msb, at most 15
    function automatic logic [3:0] prio_count(input logic [15:0] x);
        logic [3:0] n;
        logic run;
        n = 4'h0;
        run = 1'b1;
        for (int i = 14; i >= 0; i--) begin
            if (run && (x[i] == x[15])) begin
                n = n + 4'h1;
            end else begin
                run = 1'b0;
            end
        end
        return n;
    endfunction

    // arithmetic right shift with sign fill
    function automatic logic [15:0] asr16(input logic [15:0] x, input logic [3:0] n);
        return 16'($signed(x) >>> n);
    endfunction

endpackage

// File: core/bsr_rfile.sv
// two-entry left/right register file with an eight-code instruction
// assumes the code and input are stable at each rising clock edge
`timescale 1ns/10ps
module bsr_rfile
    import bsr_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic nrst, // asynchronous reset, active low
    input wire bsr_pkg::bsr_rcode_t code, // register instruction for this cycle
    input wire logic [15:0] din, // register-file input
    output logic [15:0] dout // register-file output
);

    bsr_rf_t s_q; // stored entries
    bsr_rf_t s_d; // next entries

    // output select and load decode
    always_comb begin
        s_d = s_q;
        dout = s_q.right;
        case (code)
            load_left_show_right: begin
                dout = s_q.right;
                s_d.left = din;
            end
            load_right_show_left: begin
                dout = s_q.left;
                s_d.right = din;
            end
            load_left_show_left: begin
                dout = s_q.left;
                s_d.left = din;
            end
            load_right_show_right: begin
                dout = s_q.right;
                s_d.right = din;
            end
            load_both_show_left: begin
                dout = s_q.left;
                s_d.left = din;
                s_d.right = din;
            end
            hold_show_right: begin
                dout = s_q.right;
            end
            hold_show_left: begin
                dout = s_q.left;
            end
            hold_pass_through: begin
                dout = din;
            end
            default: begin
                dout = s_q.right; // unknown code holds
            end
        endcase
    end

    // entry registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{left: BSR_RF_RST, right: BSR_RF_RST};
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_left_load: assert property ((code == load_left_show_right) |=>
        (s_q.left == $past(din)) && $stable(s_q.right))
        else $error("left load failed");
    a_right_load: assert property ((code == load_right_show_left) |=>
        (s_q.right == $past(din)) && $stable(s_q.left))
        else $error("right load failed");
    a_left_loop: assert property ((code == load_left_show_left) |->
        (dout == s_q.left) ##1 (s_q.left == $past(din)))
        else $error("left show and load failed");
    a_right_loop: assert property ((code == load_right_show_right) |->
        (dout == s_q.right) ##1 (s_q.right == $past(din)))
        else $error("right show and load failed");
    a_both_load: assert property ((code == load_both_show_left) |=>
        (s_q.left == $past(din)) && (s_q.right == $past(din)))
        else $error("both load failed");
    a_hold_right: assert property ((code == hold_show_right) |->
        (dout == s_q.right) ##1 ($stable(s_q.left) && $stable(s_q.right)))
        else $error("hold right changed state");
    a_hold_left: assert property ((code == hold_show_left) |->
        (dout == s_q.left) ##1 ($stable(s_q.left) && $stable(s_q.right)))
        else $error("hold left changed state");
    a_pass_hold: assert property ((code == hold_pass_through) |->
        (dout == din) ##1 ($stable(s_q.left) && $stable(s_q.right)))
        else $error("pass through failed");

    c_both_then_right: cover property ((code == load_both_show_left) ##1
        (code == hold_show_right));
    c_pass: cover property (code == hold_pass_through);

endmodule

// File: core/bsr_top.sv
// barrel shifter upper operations, amount registers, shift-value port and two
// left/right register files, with an apb slave for the amount and status words
// assumes the sequencer drives instruction fields and operands on clk, and the
// bench resolves the shift-value wire from the output enable
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps

module bsr_top
    import bsr_pkg::*;
(
    input wire logic CLK, // system clock, 200 MHz
    input wire logic NRST, // asynchronous reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb write when high
    input wire logic [7:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire bsr_pkg::bsr_instr_t INSTR, // instruction fields for this cycle
    input wire logic SHIFT_VALUE_OUTPUT_ENABLE, // low lets the block drive the port
    input wire logic [3:0] SHIFT_VALUE_PORT_I, // level seen on the port
    output logic [3:0] SHIFT_VALUE_PORT_O, // level driven on the port
    output logic SHIFT_VALUE_PORT_OEN, // low while the block drives the port
    input wire logic [15:0] SHIFT_IN, // barrel shifter input
    input wire logic [15:0] ALU_IN, // alu result into its register file
    output logic [15:0] SHIFT_RF_OUT, // shifter register-file output
    output logic [15:0] ALU_RF_OUT // alu register-file output
);

    bsr_state_t s_q; // registered state
    bsr_state_t s_d; // next state

    logic [15:0] shift_res; // barrel shifter result
    logic [3:0] prio; // priority-encoder count of the input
    logic is_norm; // a normalise operation is running
    logic drive_port; // block drives the shift-value port
    logic apb_setup; // apb setup cycle
    logic apb_write; // apb write completes at this edge
    logic addr_ok; // address maps to a register
    logic [31:0] rd_word; // read value of the addressed register

    // priority encoder over the shifter input
    always_comb begin
        prio = prio_count(SHIFT_IN);
    end

    // barrel shifter for the upper opcode half
    always_comb begin
        is_norm = 1'b0;
        shift_res = SHIFT_IN;
        case (INSTR.shift_op)
            load_amount_a_from_port: begin
                shift_res = SHIFT_IN;
            end
            load_amount_b_from_port: begin
                shift_res = SHIFT_IN;
            end
            arith_right_by_port_value: begin
                shift_res = asr16(SHIFT_IN, s_q.sv_reg);
            end
            arith_right_by_amount_a: begin
                shift_res = asr16(SHIFT_IN, s_q.amt_a);
            end
            arith_right_by_amount_b: begin
                shift_res = asr16(SHIFT_IN, s_q.amt_b);
            end
            normalise_only, normalise_store_a, normalise_store_b: begin
                is_norm = 1'b1;
                shift_res = SHIFT_IN << prio;
            end
            default: begin
                shift_res = SHIFT_IN; // lower opcodes live elsewhere, pass here
            end
        endcase
    end

    // shift-value port drive, enable active low
    always_comb begin
        drive_port = is_norm && !SHIFT_VALUE_OUTPUT_ENABLE;
        SHIFT_VALUE_PORT_O = drive_port ? prio : 4'h0;
        SHIFT_VALUE_PORT_OEN = !drive_port;
    end

    // apb decode and read mux
    always_comb begin
        apb_setup = PSEL && !PENABLE;
        apb_write = PSEL && PENABLE && PWRITE;
        addr_ok = (PADDR == BSR_OFS_AMOUNT) || (PADDR == BSR_OFS_STATUS);
        rd_word = 32'h00000000;
        if (PADDR == BSR_OFS_AMOUNT) begin
            rd_word[BSR_AMT_A_LSB +: 4] = s_q.amt_a;
            rd_word[BSR_AMT_B_LSB +: 4] = s_q.amt_b;
        end else if (PADDR == BSR_OFS_STATUS) begin
            rd_word[BSR_ST_SVREG_LSB +: 4] = s_q.sv_reg;
            rd_word[BSR_ST_PRIO_LSB +: 4] = prio;
            rd_word[BSR_ST_DRIVE_BIT] = drive_port;
        end
    end

    // next state: amount registers, shift-value register, apb capture
    always_comb begin
        s_d = s_q;
        // software write first, so the sequencer wins at the same edge
        if (apb_write && (PADDR == BSR_OFS_AMOUNT)) begin
            s_d.amt_a = PWDATA[BSR_AMT_A_LSB +: 4];
            s_d.amt_b = PWDATA[BSR_AMT_B_LSB +: 4];
        end
        // instruction effects taken at the closing edge of the cycle
        case (INSTR.shift_op)
            load_amount_a_from_port: begin
                s_d.amt_a = SHIFT_VALUE_PORT_I;
            end
            load_amount_b_from_port: begin
                s_d.amt_b = SHIFT_VALUE_PORT_I;
            end
            normalise_store_a: begin
                s_d.amt_a = prio;
            end
            normalise_store_b: begin
                s_d.amt_b = prio;
            end
            default: begin
                s_d.amt_a = s_d.amt_a; // no amount change
            end
        endcase
        // shift-value register follows the port while it is an input
        if (SHIFT_VALUE_OUTPUT_ENABLE) begin
            s_d.sv_reg = SHIFT_VALUE_PORT_I;
        end
        // read data and error are captured in the setup cycle
        if (apb_setup) begin
            s_d.prdata = PWRITE ? 32'h00000000 : rd_word;
            s_d.pslverr = !addr_ok;
        end
    end

    // state register
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_q <= '{amt_a: BSR_AMT_RST, amt_b: BSR_AMT_RST, sv_reg: BSR_AMT_RST,
                     prdata: BSR_RDATA_RST, pslverr: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // apb answer: zero wait states
    always_comb begin
        PREADY = PSEL && PENABLE;
        PRDATA = s_q.prdata;
        PSLVERR = PSEL && PENABLE && s_q.pslverr;
    end

    // register file behind the barrel shifter
    bsr_rfile u_shift_rf (
        .clk(CLK),
        .nrst(NRST),
        .code(INSTR.shift_rf),
        .din(shift_res),
        .dout(SHIFT_RF_OUT)
    );

    // register file behind the alu
    bsr_rfile u_alu_rf (
        .clk(CLK),
        .nrst(NRST),
        .code(INSTR.alu_rf),
        .din(ALU_IN),
        .dout(ALU_RF_OUT)
    );

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_load_a: assert property ((INSTR.shift_op == load_amount_a_from_port) |=>
        (s_q.amt_a == $past(SHIFT_VALUE_PORT_I)))
        else $error("amount a not loaded from port");
    a_load_b: assert property ((INSTR.shift_op == load_amount_b_from_port) &&
        !(apb_write && (PADDR == BSR_OFS_AMOUNT)) |=>
        (s_q.amt_b == $past(SHIFT_VALUE_PORT_I)) && $stable(s_q.amt_a))
        else $error("amount b not loaded from port");
    a_load_pass: assert property (((INSTR.shift_op == load_amount_a_from_port) ||
        (INSTR.shift_op == load_amount_b_from_port)) |-> (shift_res == SHIFT_IN))
        else $error("load instruction shifted data");
    a_asr_sign: assert property ((INSTR.shift_op == arith_right_by_amount_a) |->
        (shift_res[15] == SHIFT_IN[15]) && ((s_q.amt_a == 4'h0) || (shift_res[14] == SHIFT_IN[15])))
        else $error("arithmetic shift lost the sign");
    a_norm_bits: assert property ((is_norm && (prio != 4'hF)) |->
        (shift_res[15] != shift_res[14]) && (shift_res[3:0] == (SHIFT_IN[3:0] << prio)))
        else $error("normalise result wrong");
    a_port_drive: assert property ((is_norm && !SHIFT_VALUE_OUTPUT_ENABLE) |->
        !SHIFT_VALUE_PORT_OEN && (SHIFT_VALUE_PORT_O == prio))
        else $error("count not driven on port");
    a_store_a: assert property ((INSTR.shift_op == normalise_store_a) &&
        !(apb_write && (PADDR == BSR_OFS_AMOUNT)) |=>
        (s_q.amt_a == $past(prio)) && $stable(s_q.amt_b))
        else $error("count not stored in amount a");
    a_store_b: assert property ((INSTR.shift_op == normalise_store_b) |=>
        (s_q.amt_b == $past(prio)))
        else $error("count not stored in amount b");
    a_port_release: assert property (SHIFT_VALUE_OUTPUT_ENABLE |-> SHIFT_VALUE_PORT_OEN)
        else $error("port driven while enable high");
    a_apb_ready: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> PREADY)
        else $error("apb access not answered");

    c_norm_store: cover property ((INSTR.shift_op == normalise_store_a) ##1
        (INSTR.shift_op == arith_right_by_amount_a));
    c_port_drive: cover property (drive_port);
    c_apb_err: cover property (PSLVERR);

endmodule
